// ===== adc_cfg_top.sv
// Converter configuration, sequencing, accumulation and gain register access
// Overview of operation
// - Conversion clock is source over divider plus one
// - Non-burst: divider fed by system clock
// - Burst: divider fed by independent tick of at most 30 MHz
// - Repeat field sets conversions per interrupt
// - Non-burst: one conversion per start event
// - Burst: one start runs whole sequence
// - Results arriving while converting accumulate into result bytes
// - Encodings 00,01,10 give 1,4,8 conversions
// - Right, repeat 00: high byte four bits
// - Right, repeat 01: high byte five bits
// - Right, repeat 10: high byte six bits
// - Right, repeat 11: high byte eight bits
// - Left justified: high byte top eight bits
// - Config bit 0 enables gain programming
// - Gain on: high selects, low loads gain
// - Left justified: low byte bits 7:4 hold lsbs
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire adc_cfg_pkg::sfr_req_t sfr,
	output logic [7:0] sfr_rdata,
	input wire logic burst_mode_enable,
	input wire logic left_justify_select,
	input wire logic convert_start,
	input wire logic burst_src_tick,
	output logic conv_req,
	input wire adc_cfg_pkg::sample_t sample,
	output logic conversion_done_interrupt,
	output logic busy,
	output logic conversion_clock_tick,
	output adc_cfg_pkg::gain_regs_t gain_regs
);
	import adc_cfg_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_WAIT_START} seq_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] gain_addr;
		gain_regs_t gain;
		logic [15:0] acc;
		logic [4:0] done_cnt;
		seq_t st;
		logic req;
		logic done;
		logic [7:0] rdata;
		logic [1:0] burst_sync;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;
	logic src_tick;
	logic div_run;
	logic conv_tick;
	logic [7:0] fmt_high;
	logic [7:0] fmt_low;
	logic [4:0] seq_len;
	logic gain_on;
	logic burst_tick;

	// Burst source tick comes from another clock and is synchronised first
	assign burst_tick = s_q.burst_sync[1];
	assign src_tick = burst_mode_enable ? burst_tick : 1'b1;
	assign div_run = (s_q.st == ST_CONVERT);
	assign seq_len = repeat_len(s_q.cfg[RPT_MSB:RPT_LSB]);
	assign gain_on = s_q.cfg[GAIN_EN_BIT];

	clk_div u_div (
		.mclk(mclk),
		.nrst(nrst),
		.src_tick(src_tick),
		.div(s_q.cfg[DIV_MSB:DIV_LSB]),
		.run(div_run),
		.conv_tick(conv_tick)
	);

	result_fmt u_fmt (
		.acc(s_q.acc),
		.rpt(s_q.cfg[RPT_MSB:RPT_LSB]),
		.ljust(left_justify_select),
		.high_byte(fmt_high),
		.low_byte(fmt_low)
	);

	// Register access, sequencing and accumulation
	always_comb begin
		s_d = s_q;
		s_d.burst_sync = {s_q.burst_sync[0], burst_src_tick};
		s_d.req = 1'b0;
		s_d.done = 1'b0;
		// Register writes
		if (sfr.wr) begin
			if (sfr.addr == ADDR_CONFIG) begin
				s_d.cfg = sfr.wdata;
			end else if (sfr.addr == ADDR_RES_HIGH && gain_on) begin
				s_d.gain_addr = sfr.wdata;
			end else if (sfr.addr == ADDR_RES_LOW && gain_on) begin
				if (s_q.gain_addr == GAIN_ADDR_HIGH) begin
					s_d.gain.high_byte = sfr.wdata;
				end else if (s_q.gain_addr == GAIN_ADDR_LOW) begin
					s_d.gain.low_nibble = {sfr.wdata[7:4], 4'h0};
				end else if (s_q.gain_addr == GAIN_ADDR_EXTRA) begin
					s_d.gain.extra_step = {7'h00, sfr.wdata[0]};
				end
			end else if (sfr.addr == ADDR_RES_HIGH) begin
				s_d.acc[15:8] = sfr.wdata;
			end else if (sfr.addr == ADDR_RES_LOW) begin
				s_d.acc[7:0] = sfr.wdata;
			end
		end
		// Register reads; unmapped addresses read zero
		if (sfr.addr == ADDR_CONFIG) begin
			s_d.rdata = s_q.cfg;
		end else if (sfr.addr == ADDR_RES_HIGH) begin
			s_d.rdata = fmt_high;
		end else if (sfr.addr == ADDR_RES_LOW) begin
			s_d.rdata = fmt_low;
		end else begin
			s_d.rdata = 8'h00;
		end
		// Conversion sequencer
		case (s_q.st)
			ST_IDLE: begin
				if (convert_start) begin
					s_d.acc = 16'h0000;
					s_d.done_cnt = 5'h00;
					s_d.st = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (conv_tick) begin
					s_d.req = 1'b1;
				end
				if (sample.valid) begin
					s_d.acc = s_q.acc + {4'h0, sample.code};
					s_d.done_cnt = s_q.done_cnt + 5'h01;
					if (s_q.done_cnt + 5'h01 >= seq_len) begin
						s_d.done = 1'b1;
						s_d.st = ST_IDLE;
					end else if (!burst_mode_enable) begin
						s_d.st = ST_WAIT_START;
					end else begin
						s_d.st = ST_CONVERT;
					end
				end
			end
			default: begin
				if (convert_start) begin
					s_d.st = ST_CONVERT;
				end
			end
		endcase
	end

	// Single register for all state; reset values as documented
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_q.cfg <= CONFIG_RESET;
			s_q.gain_addr <= 8'h00;
			s_q.gain <= {GAIN_HIGH_RESET, GAIN_LOW_RESET, GAIN_EXTRA_RESET};
			s_q.acc <= {RESULT_RESET, RESULT_RESET};
			s_q.done_cnt <= 5'h00;
			s_q.st <= ST_IDLE;
			s_q.req <= 1'b0;
			s_q.done <= 1'b0;
			s_q.rdata <= 8'h00;
			s_q.burst_sync <= 2'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sfr_rdata = s_q.rdata;
	assign conv_req = s_q.req;
	assign conversion_done_interrupt = s_q.done;
	assign busy = (s_q.st != ST_IDLE);
	assign conversion_clock_tick = conv_tick;
	assign gain_regs = s_q.gain;

	// Sequence of steps checked below
	sequence start_idle_s;
		s_q.st == ST_IDLE && convert_start;
	endsequence

	sequence last_sample_s;
		s_q.st == ST_CONVERT && sample.valid && (s_q.done_cnt + 5'h01 >= seq_len);
	endsequence

	seq_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		start_idle_s |=> (s_q.acc == 16'h0000 && s_q.done_cnt == 5'h00))
		else $error("accumulator not cleared at sequence start");
	done_count_a: assert property (@(posedge mclk) disable iff (!nrst)
		last_sample_s |=> conversion_done_interrupt && !busy)
		else $error("done not raised after last conversion");
	no_early_done_a: assert property (@(posedge mclk) disable iff (!nrst)
		conversion_done_interrupt |-> $past(s_q.done_cnt) + 5'h01 == seq_len)
		else $error("done raised with wrong conversion count");
	accum_sum_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st == ST_CONVERT && sample.valid && !sfr.wr)
		|=> s_q.acc == $past(s_q.acc) + {4'h0, $past(sample.code)})
		else $error("sample not accumulated");
	nonburst_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st == ST_CONVERT && sample.valid && !burst_mode_enable
		&& s_q.done_cnt + 5'h01 < seq_len) |=> s_q.st == ST_WAIT_START)
		else $error("non-burst ran on without a start");
	burst_run_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st == ST_CONVERT && sample.valid && burst_mode_enable
		&& s_q.done_cnt + 5'h01 < seq_len) |=> s_q.st == ST_CONVERT)
		else $error("burst sequence stopped early");
	gain_load_a: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr.wr && gain_on && sfr.addr == ADDR_RES_LOW && s_q.gain_addr == GAIN_ADDR_HIGH)
		|=> gain_regs.high_byte == $past(sfr.wdata))
		else $error("gain high byte not loaded");
	cfg_store_a: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr.wr && sfr.addr == ADDR_CONFIG) |=> gain_on == $past(sfr.wdata[0]))
		else $error("gain enable not taken from bit 0");
	right_pad_a: assert property (@(posedge mclk) disable iff (!nrst)
		(!left_justify_select && s_q.cfg[RPT_MSB:RPT_LSB] == 2'b00) |-> fmt_high[7:4] == 4'h0)
		else $error("high byte upper bits not zero");
	left_low_a: assert property (@(posedge mclk) disable iff (!nrst)
		left_justify_select |-> fmt_low[3:0] == 4'h0)
		else $error("left justified low nibble not zero");

	// Burst ticks reach the divider only after both synchroniser stages
	sequence burst_rise_s;
		burst_mode_enable && $rose(burst_tick);
	endsequence

	// A start while waiting resumes converting and keeps the running sum
	sequence wait_start_s;
		s_q.st == ST_WAIT_START && convert_start;
	endsequence

	// Gain programming: result high byte takes the address, low byte the data
	sequence gain_addr_write_s;
		sfr.wr && gain_on && sfr.addr == ADDR_RES_HIGH;
	endsequence

	sequence gain_data_write_s;
		sfr.wr && gain_on && sfr.addr == ADDR_RES_LOW;
	endsequence

	// Clock source selection and divider request path
	src_system_a: assert property (@(posedge mclk) disable iff (!nrst)
		!burst_mode_enable |-> src_tick)
		else $error("divider source not the system clock");
	src_burst_a: assert property (@(posedge mclk) disable iff (!nrst)
		burst_rise_s |-> $past(burst_src_tick, 2))
		else $error("burst tick bypassed the synchroniser");
	cfg_whole_a: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr.wr && sfr.addr == ADDR_CONFIG) |=> s_q.cfg == $past(sfr.wdata))
		else $error("configuration write not stored");
	tick_req_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st == ST_CONVERT && conv_tick) |=> conv_req)
		else $error("conversion clock edge did not request a sample");
	idle_no_req_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st != ST_CONVERT) |=> !conv_req)
		else $error("sample requested outside a conversion");

	// Sequencing: starts, waits and the done pulse
	busy_start_a: assert property (@(posedge mclk) disable iff (!nrst)
		start_idle_s |=> busy && s_q.st == ST_CONVERT)
		else $error("start did not begin converting");
	wait_resume_a: assert property (@(posedge mclk) disable iff (!nrst)
		wait_start_s |=> s_q.st == ST_CONVERT)
		else $error("start did not resume the sequence");
	wait_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st == ST_WAIT_START && !convert_start) |=> s_q.st == ST_WAIT_START)
		else $error("sequence resumed without a start");
	done_single_a: assert property (@(posedge mclk) disable iff (!nrst)
		conversion_done_interrupt |=> !conversion_done_interrupt)
		else $error("done held longer than one cycle");
	idle_sample_a: assert property (@(posedge mclk) disable iff (!nrst)
		(s_q.st == ST_IDLE && sample.valid && !convert_start && !sfr.wr)
		|=> $stable(s_q.acc))
		else $error("sample accumulated while idle");

	// Gain registers are write-only and must leave the result alone
	gain_addr_a: assert property (@(posedge mclk) disable iff (!nrst)
		gain_addr_write_s |=> s_q.gain_addr == $past(sfr.wdata))
		else $error("gain address not taken");
	gain_low_a: assert property (@(posedge mclk) disable iff (!nrst)
		gain_data_write_s ##0 (s_q.gain_addr == GAIN_ADDR_LOW)
		|=> gain_regs.low_nibble == {$past(sfr.wdata[7:4]), 4'h0})
		else $error("gain low nibble not loaded");
	gain_extra_a: assert property (@(posedge mclk) disable iff (!nrst)
		gain_data_write_s ##0 (s_q.gain_addr == GAIN_ADDR_EXTRA)
		|=> gain_regs.extra_step == {7'h00, $past(sfr.wdata[0])})
		else $error("gain extra step not loaded");
	gain_guard_a: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr.wr && gain_on && s_q.st == ST_IDLE && !convert_start
		&& (sfr.addr == ADDR_RES_HIGH || sfr.addr == ADDR_RES_LOW)) |=> $stable(s_q.acc))
		else $error("gain write reached the result");

	// Read data and the remaining result formats
	read_cfg_a: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr.addr == ADDR_CONFIG) |=> sfr_rdata == $past(s_q.cfg))
		else $error("configuration read data wrong");
	read_high_a: assert property (@(posedge mclk) disable iff (!nrst)
		(sfr.addr == ADDR_RES_HIGH) |=> sfr_rdata == $past(fmt_high))
		else $error("result high read data wrong");
	right_five_a: assert property (@(posedge mclk) disable iff (!nrst)
		(!left_justify_select && s_q.cfg[RPT_MSB:RPT_LSB] == 2'b01)
		|-> fmt_high[7:5] == 3'h0)
		else $error("four-sample high byte not padded");
	right_six_a: assert property (@(posedge mclk) disable iff (!nrst)
		(!left_justify_select && s_q.cfg[RPT_MSB:RPT_LSB] == 2'b10)
		|-> fmt_high[7:6] == 2'h0)
		else $error("eight-sample high byte not padded");
	right_full_a: assert property (@(posedge mclk) disable iff (!nrst)
		(!left_justify_select && s_q.cfg[RPT_MSB:RPT_LSB] == 2'b11)
		|-> fmt_high == s_q.acc[15:8])
		else $error("sixteen-sample high byte wrong");
	left_high_a: assert property (@(posedge mclk) disable iff (!nrst)
		left_justify_select |-> fmt_high == s_q.acc[11:4])
		else $error("left justified high byte wrong");
endmodule
`default_nettype wire

// ===== adc_cfg_pkg.sv
// Package: register addresses, field layout, reset values and types of the converter block
`default_nettype none
package adc_cfg_pkg;
	// Special function register addresses
	localparam logic [7:0] ADDR_CONFIG = 8'hbc;
	localparam logic [7:0] ADDR_RES_LOW = 8'hbd;
	localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
	// Configuration field positions and reset value
	localparam int DIV_MSB = 7;
	localparam int DIV_LSB = 3;
	localparam int RPT_MSB = 2;
	localparam int RPT_LSB = 1;
	localparam int GAIN_EN_BIT = 0;
	localparam logic [7:0] CONFIG_RESET = 8'hf8;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	// Indirect gain register addresses and reset values
	localparam logic [7:0] GAIN_ADDR_HIGH = 8'h04;
	localparam logic [7:0] GAIN_ADDR_LOW = 8'h07;
	localparam logic [7:0] GAIN_ADDR_EXTRA = 8'h08;
	localparam logic [7:0] GAIN_HIGH_RESET = 8'hfc;
	localparam logic [7:0] GAIN_LOW_RESET = 8'h00;
	localparam logic [7:0] GAIN_EXTRA_RESET = 8'h01;
	// Burst source clock ceiling and system clock rate
	localparam int BURST_SRC_MAX_MHZ = 30;
	localparam int SYS_CLK_MHZ = 125;

	// Repeat count encodings
	typedef enum logic [1:0] {RPT_ONE = 2'b00, RPT_FOUR = 2'b01, RPT_EIGHT = 2'b10,
		RPT_SIXTEEN = 2'b11} repeat_t;

	// Special function register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// Write-only gain registers
	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_nibble;
		logic [7:0] extra_step;
	} gain_regs_t;

	// Conversion sample from the analog core
	typedef struct packed {
		logic valid;
		logic [11:0] code;
	} sample_t;

	// Number of conversions for a repeat setting
	function automatic logic [4:0] repeat_len(input logic [1:0] rpt);
		case (rpt)
			2'b00: repeat_len = 5'h01;
			2'b01: repeat_len = 5'h04;
			2'b10: repeat_len = 5'h08;
			default: repeat_len = 5'h10;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== clk_div.sv
// Conversion clock divider: one enable pulse every div+1 source ticks
`timescale 1ns/1ps
`default_nettype none
module clk_div (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic src_tick,
	input wire logic [4:0] div,
	input wire logic run,
	output logic conv_tick
);
	import adc_cfg_pkg::*;

	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} div_state_t;

	div_state_t s_q;
	div_state_t s_d;

	// Count source ticks; restart whenever the divider is idle
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run) begin
			s_d.cnt = 5'h00;
		end else if (src_tick) begin
			if (s_q.cnt >= div) begin
				s_d.cnt = 5'h00;
				s_d.tick = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign conv_tick = s_q.tick;

	// Period of the divided clock is exactly div+1 source ticks
	div_period_a: assert property (@(posedge mclk) disable iff (!nrst)
		(run && src_tick && s_q.cnt == div) |=> conv_tick)
		else $error("divider did not tick at div+1");
endmodule
`default_nettype wire

// ===== result_fmt.sv
// Result formatter: justifies the accumulated sum into high and low bytes
`timescale 1ns/1ps
`default_nettype none
module result_fmt (
	input wire logic [15:0] acc,
	input wire logic [1:0] rpt,
	input wire logic ljust,
	output logic [7:0] high_byte,
	output logic [7:0] low_byte
);
	import adc_cfg_pkg::*;

	// Right-justified high byte width grows with the repeat count
	always_comb begin
		low_byte = acc[7:0];
		if (ljust) begin
			high_byte = acc[11:4];
			low_byte = {acc[3:0], 4'h0};
		end else begin
			case (rpt)
				2'b00: high_byte = {4'h0, acc[11:8]};
				2'b01: high_byte = {3'h0, acc[12:8]};
				2'b10: high_byte = {2'h0, acc[13:8]};
				default: high_byte = acc[15:8];
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== adc_core_model.sv
// Behavioural analog core that answers sample requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic conv_req,
	input wire logic [7:0] lat,
	input wire logic [11:0] seed,
	output adc_cfg_pkg::sample_t sample
);
	import adc_cfg_pkg::*;
	logic [7:0] cnt_q;
	logic pend_q;
	logic vld_q;
	logic [11:0] code_q;
	// One request in flight; requests arriving meanwhile are dropped, as a busy core would
	always_ff @(posedge mclk) begin
		vld_q <= 1'b0;
		if (!nrst) begin
			pend_q <= 1'b0;
			cnt_q <= 8'h00;
			code_q <= seed;
		end else if (pend_q) begin
			cnt_q <= cnt_q - 8'h01;
			if (cnt_q == 8'h00) begin
				pend_q <= 1'b0;
				vld_q <= 1'b1;
				code_q <= code_q * 12'h005 + seed;
			end
		end else if (conv_req) begin
			pend_q <= 1'b1;
			cnt_q <= lat;
		end
	end
	// Code lines carry the inverse outside the valid cycle so stale data cannot pass
	assign sample = {vld_q, vld_q ? code_q : ~code_q};
endmodule
`default_nettype wire

// ===== adc_config_result_format_test.sv
// Self-checking bench for the converter configuration and result block
`timescale 1ns/1ps
`default_nettype none
module adc_config_result_format_test;
	import adc_cfg_pkg::*;
	logic mclk, nrst, bst, ljs, cst, btick, conv_req, done, busy, ctick, rd_d;
	logic [7:0] sfr_rdata, lat;
	logic [11:0] seed;
	logic [15:0] sum;
	sfr_req_t sfr;
	sample_t sample;
	gain_regs_t gain_regs;
	logic [7:0] exp_q[$];
	int error_cnt, checks_done, nsmp, ndone, cyc, last, gap, armed, quota;
	adc_cfg_top dut_u (.mclk(mclk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.burst_mode_enable(bst), .left_justify_select(ljs), .convert_start(cst),
		.burst_src_tick(btick), .conv_req(conv_req), .sample(sample),
		.conversion_done_interrupt(done), .busy(busy), .conversion_clock_tick(ctick),
		.gain_regs(gain_regs));
	adc_core_model core_u (.mclk(mclk), .nrst(nrst), .conv_req(conv_req), .lat(lat),
		.seed(seed), .sample(sample));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Burst source: one-cycle pulse every 5 cycles, 25 MHz
	initial begin
		btick = 1'b0;
		forever begin
			repeat (4) @(posedge mclk);
			#1 btick = 1'b1;
			@(posedge mclk);
			#1 btick = 1'b0;
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watcher; tick spacing is only judged between two ticks of one pending request
	always @(posedge mclk) begin
		cyc++;
		rd_d <= sfr.rd;
		// Only samples the block takes count: one per start, or a whole burst
		if (sample.valid && armed > 0) begin
			nsmp++;
			sum += 16'(sample.code);
			armed--;
		end else if (cst && armed == 0) begin
			armed = quota;
		end
		if (sample.valid || cst) last = 0;
		if (ctick) begin
			if (last != 0) chk(24'(cyc - last), 24'(gap));
			last = cyc;
		end
		if (done) ndone++;
	end
	// Read data is registered, so it is judged one cycle after the address
	always @(negedge mclk) begin
		if (rd_d) chk(24'(sfr_rdata), 24'(exp_q.pop_front()));
	end
	// Every call assigns each input once, then lets one edge pass
	task automatic drive(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d, input logic s);
		sfr = '{w, r, a, d};
		cst = s;
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		drive(1'b0, 1'b1, a, 8'h00, 1'b0);
	endtask
	task automatic idle(input int n);
		repeat (n) drive(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
	endtask
	task automatic waitc(ref int v, input int want);
		for (int i = 0; i < 4000 && v < want; i++) idle(1);
		if (v < want) begin
			error_cnt++;
			stop_test();
		end
	endtask
	task automatic run(input logic [1:0] rpt, input logic lj, input logic b,
		input logic [4:0] div);
		int n;
		int n0;
		logic [7:0] hi;
		logic [7:0] lo;
		n = (rpt == 2'b00) ? 1 : 2 << rpt;
		bst = b;
		ljs = lj;
		seed = 12'($urandom);
		gap = b ? 5 * (div + 1) : div + 1;
		quota = b ? n : 1;
		lat = 8'(2 * gap + 1);
		drive(1'b1, 1'b0, 8'hbc, {div, rpt, 1'b0}, 1'b0);
		nsmp = 0;
		sum = 16'h0000;
		n0 = ndone;
		if (b) begin
			drive(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
			drive(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
			chk(24'(busy), 24'(armed > 0));
		end else begin
			for (int k = 0; k < n; k++) begin
				drive(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
				waitc(nsmp, k + 1);
				idle(60);
				chk(24'(nsmp), 24'(k + 1));
				chk(24'(busy), 24'(k + 1 < n));
			end
		end
		waitc(ndone, n0 + 1);
		idle(2);
		chk(24'(ndone - n0), 24'h1);
		chk(24'(busy), 24'h0);
		chk(24'(nsmp), 24'(n));
		hi = lj ? sum[11:4] : rpt == 2'b00 ? {4'h0, sum[11:8]} : rpt == 2'b01 ?
			{3'h0, sum[12:8]} : rpt == 2'b10 ? {2'h0, sum[13:8]} : sum[15:8];
		lo = lj ? {sum[3:0], 4'h0} : sum[7:0];
		rd(8'hbe, hi);
		rd(8'hbd, lo);
		idle(2);
		$display("Test done: burst %0d repeat %0d left %0d", b, rpt, lj);
	endtask
	initial begin
		nrst = 1'b0;
		sfr = '0;
		bst = 1'b0;
		ljs = 1'b0;
		cst = 1'b0;
		lat = 8'h02;
		seed = 12'($urandom(32'h71ba));
		repeat (8) @(posedge mclk);
		#1 nrst = 1'b1;
		rd(8'hbc, 8'hf8);
		rd(8'hbe, 8'h00);
		rd(8'hbd, 8'h00);
		rd(8'hc3, 8'h00);
		drive(1'b1, 1'b0, 8'hbe, 8'hc3, 1'b0);
		drive(1'b1, 1'b0, 8'hbd, 8'h5a, 1'b0);
		rd(8'hbe, 8'h03);
		rd(8'hbd, 8'h5a);
		chk(gain_regs, 24'hfc0001);
		$display("Test done: reset values");
		drive(1'b1, 1'b0, 8'hbc, 8'h01, 1'b0);
		drive(1'b1, 1'b0, 8'hbe, 8'h04, 1'b0);
		drive(1'b1, 1'b0, 8'hbd, 8'h6c, 1'b0);
		drive(1'b1, 1'b0, 8'hbe, 8'h07, 1'b0);
		drive(1'b1, 1'b0, 8'hbd, 8'ha5, 1'b0);
		drive(1'b1, 1'b0, 8'hbe, 8'h08, 1'b0);
		drive(1'b1, 1'b0, 8'hbd, 8'hfe, 1'b0);
		drive(1'b1, 1'b0, 8'hbe, 8'h05, 1'b0);
		drive(1'b1, 1'b0, 8'hbd, 8'h33, 1'b0);
		idle(1);
		chk(gain_regs, 24'h6ca000);
		rd(8'hbc, 8'h01);
		drive(1'b1, 1'b0, 8'hbc, 8'hf8, 1'b0);
		rd(8'hbe, 8'h03);
		idle(2);
		$display("Test done: gain programming");
		for (int b = 0; b < 2; b++) begin
			for (int r = 0; r < 5; r++) run(2'(r % 4), r == 4, b[0], 5'($urandom_range(3, 0)));
		end
		stop_test();
	end
endmodule
`default_nettype wire
